/* design/ohp_host_port.sv */
// Host bus port of the display module: parallel and serial byte intake
// Function
// - Eight-bit bidirectional host bus, both directions in 6800 and 8080 modes; serial modes write only
// - Serial mode: bit1 data, bit0 clock
// - 6800 mode: enable strobe starts access
// - 8080 mode: read strobe low starts read
// - 6800 mode: direction pin high read, low write
// - 8080 mode: write strobe low starts write
// - Select high means display data byte; three-wire serial mode ignores select and routes every byte to command
// - Select low routes byte to command register
// - Reset low initializes controller logic
// - Respond only while chip select low
// - 6800 capture byte at enable falling edge
// - 8080 latch on write/read strobe rising edge
`timescale 1ns/1ps
`default_nettype none
module ohp_host_port (
	input  wire logic             clock_in,
	input  wire logic             srst_in,
	input  wire logic [1:0]       mode_in,
	input  wire logic [7:0]       host_bus_in,
	output logic      [7:0]       host_bus_out,
	output logic                  host_bus_oe_out,
	input  wire logic             strobe_a_in,
	input  wire logic             strobe_b_in,
	input  wire logic             chip_select_n_in,
	input  wire logic             data_command_select_in,
	input  wire logic             reset_n_in,
	input  wire logic [7:0]       read_data_in,
	input  wire logic [7:0]       status_in,
	output logic      [7:0]       cmd_byte_out,
	output logic                  cmd_valid_out,
	output logic      [7:0]       data_byte_out,
	output logic                  data_valid_out,
	output logic                  read_ack_out,
	output logic                  read_is_data_out,
	output logic                  init_out
);
	typedef struct packed {
		ohp_pkg::ohp_state_e state;
		logic                a_d;
		logic                b_d;
		logic [7:0]          shift;
		logic [2:0]          cnt;
		logic [7:0]          cmd_byte;
		logic                cmd_valid;
		logic [7:0]          data_byte;
		logic                data_valid;
		logic                read_ack;
		logic                read_is_data;
		logic [7:0]          bus_out;
		logic                bus_oe;
		logic                init;
	} ohp_state_s;

	ohp_state_s r;
	ohp_state_s next_r;

	logic       sclk;
	logic       serial_in;
	logic       a_now;
	logic       a_rise;
	logic       a_fall;
	logic       b_rise;
	logic       b_fall;
	logic       serial_mode;
	logic       spi4_mode;
	logic [7:0] rd_byte;
	logic [7:0] serial_byte;

	logic       wr_fire;
	logic       wr_is_data;
	logic [7:0] wr_byte;

	assign sclk        = host_bus_in[ohp_pkg::SCLK_BIT];
	assign serial_in   = host_bus_in[ohp_pkg::SERIAL_IN_BIT];
	assign spi4_mode   = (mode_in == ohp_pkg::MODE_SPI4);
	assign serial_mode = spi4_mode || (mode_in == ohp_pkg::MODE_SPI3);
	// In parallel modes strobe A carries E or RD; serial uses bus clock
	assign a_now       = serial_mode ? sclk : strobe_a_in;
	assign a_rise      = a_now & ~r.a_d;
	assign a_fall      = ~a_now & r.a_d;
	assign b_rise      = strobe_b_in & ~r.b_d;
	assign b_fall      = ~strobe_b_in & r.b_d;
	// Select picks display memory or status for a read
	assign rd_byte     = data_command_select_in ? read_data_in : status_in;
	// MSB first, so the newest bit lands at the bottom
	assign serial_byte = {r.shift[6:0], serial_in};

	always_comb begin
		next_r            = r;
		next_r.cmd_valid  = 1'h0;
		next_r.data_valid = 1'h0;
		next_r.read_ack   = 1'h0;
		next_r.a_d        = a_now;
		next_r.b_d        = strobe_b_in;
		next_r.state      = ohp_pkg::OHP_IDLE;
		next_r.init       = 1'h0;
		wr_fire           = 1'h0;
		wr_is_data        = 1'h0;
		wr_byte           = ohp_pkg::BYTE_ZERO;

		if (chip_select_n_in) begin
			// Deselect drops bus and aborts a partial serial byte
			next_r.bus_oe = 1'h0;
			next_r.cnt    = ohp_pkg::CNT_ZERO;
			next_r.shift  = ohp_pkg::BYTE_ZERO;
		end else begin
			// Mode is a strap: changing it mid-access may fake an edge
			case (mode_in)
				ohp_pkg::MODE_6800: begin
					// Direction pin high means read, driving in E high
					if (a_rise && strobe_b_in) begin
						next_r.bus_out = rd_byte;
						next_r.bus_oe  = 1'h1;
					end

					if (a_fall) begin
						next_r.bus_oe = 1'h0;
						if (strobe_b_in) begin
							next_r.read_ack     = 1'h1;
							next_r.read_is_data = data_command_select_in;
						end else begin
							wr_fire    = 1'h1;
							wr_is_data = data_command_select_in;
							wr_byte    = host_bus_in;
						end
					end
				end

				ohp_pkg::MODE_8080: begin
					// Bus is driven from RD fall until RD rise
					if (a_fall) begin
						next_r.bus_out = rd_byte;
						next_r.bus_oe  = 1'h1;
					end

					if (a_rise) begin
						next_r.bus_oe       = 1'h0;
						next_r.read_ack     = 1'h1;
						next_r.read_is_data = data_command_select_in;
					end

					// Write start only makes sure the bus is released
					if (b_fall) begin
						next_r.bus_oe = 1'h0;
					end

					if (b_rise) begin
						wr_fire    = 1'h1;
						wr_is_data = data_command_select_in;
						wr_byte    = host_bus_in;
					end
				end

				default: begin
					// Serial write only; reads are not possible here
					next_r.bus_oe = 1'h0;
					if (a_rise) begin
						next_r.shift = serial_byte;
						next_r.cnt   = r.cnt + ohp_pkg::CNT_ONE;
						if (r.cnt == ohp_pkg::CNT_LAST) begin
							// Three-wire frames carry no select: all command
							wr_fire    = 1'h1;
							wr_is_data = spi4_mode && data_command_select_in;
							wr_byte    = serial_byte;
						end
					end
				end
			endcase
		end

		// One steering point keeps every mode's routing identical
		if (wr_fire) begin
			if (wr_is_data) begin
				next_r.data_byte  = wr_byte;
				next_r.data_valid = 1'h1;
			end else begin
				next_r.cmd_byte  = wr_byte;
				next_r.cmd_valid = 1'h1;
			end
		end

		// Pin reset clears the controller side, not just the port
		if (!reset_n_in) begin
			next_r       = '0;
			next_r.state = ohp_pkg::OHP_INIT;
			next_r.init  = 1'h1;
			next_r.a_d   = a_now;
			next_r.b_d   = strobe_b_in;
		end

		// Edge history follows the pins in reset: no false edge on release
		if (srst_in) begin
			next_r       = '0;
			next_r.state = ohp_pkg::OHP_INIT;
			next_r.init  = 1'h1;
			next_r.a_d   = a_now;
			next_r.b_d   = strobe_b_in;
		end
	end

	// Limitation: each strobe level must last at least one clock, since edges
	// are found only against the previous sample
	always_ff @(posedge clock_in) begin
		r <= next_r;
	end

	// All outputs straight from the state register
	assign host_bus_out     = r.bus_out;
	assign host_bus_oe_out  = r.bus_oe;
	assign cmd_byte_out     = r.cmd_byte;
	assign cmd_valid_out    = r.cmd_valid;
	assign data_byte_out    = r.data_byte;
	assign data_valid_out   = r.data_valid;
	assign read_ack_out     = r.read_ack;
	assign read_is_data_out = r.read_is_data;
	assign init_out         = r.init;
endmodule // ohp_host_port
`default_nettype wire

/* design/ohp_pkg.sv */
// Constants for the display host port
package ohp_pkg;
	localparam int          BUS_W     = 8;
	localparam int          SCLK_BIT  = 0;
	localparam int          SERIAL_IN_BIT = 1;
	localparam logic [1:0]  MODE_6800 = 2'h0;
	localparam logic [1:0]  MODE_8080 = 2'h1;
	localparam logic [1:0]  MODE_SPI4 = 2'h2;
	localparam logic [1:0]  MODE_SPI3 = 2'h3;
	localparam logic [2:0]  CNT_ZERO  = 3'h0;
	localparam logic [2:0]  CNT_ONE   = 3'h1;
	localparam logic [2:0]  CNT_LAST  = 3'h7;
	localparam logic [7:0]  BYTE_ZERO = 8'h00;
	localparam logic [7:0]  STATUS_RV = 8'h00;
	typedef enum logic [1:0] {
		OHP_IDLE = 2'h1,
		OHP_INIT = 2'h2
	} ohp_state_e;
endpackage

/* tb/ohp_host_model.sv */
// Host side model: parallel and serial bus accesses
`timescale 1ns/1ps
`default_nettype none
module ohp_host_model (
	input  wire logic       clock_in,
	input  wire logic [1:0] mode_in,
	input  wire logic [7:0] bus_in,
	output logic      [7:0] bus_out = 8'h00,
	output logic            sa_out = 1'h0,
	output logic            sb_out = 1'h0,
	output logic            cs_n_out = 1'h1,
	output logic            dc_out = 1'h0
);
	logic [7:0] got;
	task automatic hold();
		repeat (2) @(posedge clock_in);
		#1;
	endtask
	task automatic xfer(input logic cs_n, rd, dcs, input logic [7:0] b);
		logic m8;
		m8 = mode_in == ohp_pkg::MODE_8080;
		// Strobes settle idle before select, so no edge meets it
		{sa_out, sb_out} = {m8, m8 | rd};
		dc_out = dcs;
		hold();
		cs_n_out = cs_n;
		if (mode_in[1]) begin
			for (int i = 7; i >= 0; i--) begin
				bus_out = {6'h00, b[i], 1'h0};
				hold();
				bus_out[0] = 1'h1;
				hold();
			end
			bus_out[0] = 1'h0;
		end else begin
			bus_out = rd ? ~b : b;
			hold();
			{sa_out, sb_out} = {~m8 | ~rd, rd};
			hold();
			got = bus_in;
			{sa_out, sb_out} = {m8, m8 | rd};
		end
		hold();
		cs_n_out = 1'h1;
		bus_out = ~bus_out;
		hold();
	endtask
endmodule // ohp_host_model
`default_nettype wire

/* tb/ohp_host_port_assertions.sv */
// Timing checks on the display host port pins
`timescale 1ns/1ps
`default_nettype none
module ohp_host_port_chk (
	input wire logic       clock_in,
	input wire logic       srst_in,
	input wire logic [1:0] mode_in,
	input wire logic [7:0] host_bus_in,
	input wire logic       host_bus_oe_out,
	input wire logic       strobe_a_in,
	input wire logic       strobe_b_in,
	input wire logic       chip_select_n_in,
	input wire logic       data_command_select_in,
	input wire logic       reset_n_in,
	input wire logic [7:0] cmd_byte_out,
	input wire logic       cmd_valid_out,
	input wire logic [7:0] data_byte_out,
	input wire logic       data_valid_out,
	input wire logic       read_ack_out,
	input wire logic       init_out
);
	wire logic       go = !chip_select_n_in && reset_n_in;
	wire logic       m8 = mode_in == ohp_pkg::MODE_8080;
	wire logic       m6 = mode_in == ohp_pkg::MODE_6800;
	wire logic       dcs = data_command_select_in;
	wire logic [7:0] hb = host_bus_in;
	default clocking @(posedge clock_in); endclocking
	default disable iff (srst_in);
	chk_wr_data: assert property (m8 && go && $rose(strobe_b_in) && dcs
		|=> data_valid_out && data_byte_out == $past(hb)) else $error("no data");
	chk_e_cmd: assert property (m6 && go && $fell(strobe_a_in) && !dcs
		&& !strobe_b_in |=> cmd_valid_out && cmd_byte_out == $past(hb))
		else $error("no command");
	chk_idle_quiet: assert property (chip_select_n_in |=> !cmd_valid_out
		&& !data_valid_out && !host_bus_oe_out) else $error("acted unselected");
	chk_rd_start: assert property (m8 && go && $fell(strobe_a_in)
		|=> host_bus_oe_out) else $error("read not driven");
	chk_e_read: assert property (m6 && go && $rose(strobe_a_in) && strobe_b_in
		|=> host_bus_oe_out) else $error("6800 read not driven");
	chk_rd_end: assert property (m8 && go && $rose(strobe_a_in)
		&& host_bus_oe_out |=> read_ack_out && !host_bus_oe_out) else $error("no ack");
	chk_wr_open: assert property (m8 && go && $fell(strobe_b_in)
		|=> !host_bus_oe_out ##1 !cmd_valid_out && !data_valid_out)
		else $error("early write");
	chk_pin_init: assert property (!reset_n_in |=> init_out)
		else $error("no init");
endmodule // ohp_host_port_chk
bind ohp_host_port ohp_host_port_chk ohp_host_port_chk_inst (.*);
`default_nettype wire

/* tb/ohp_host_port_tb_top.sv */
// Testbench for the display host port
`timescale 1ns/1ps
`default_nettype none
module ohp_host_port_tb_top;
	typedef struct packed {logic [1:0] mode; logic cs_n, rd, dcs;
		logic [7:0] b; logic [1:0] k;} ohp_row_s;
	logic clock_in = 1'h0, srst_in = 1'h1, reset_n_in = 1'h1;
	logic [1:0] mode_in = 2'h0;
	logic [7:0] mbus, host_bus_out, cmd_byte_out, data_byte_out, v;
	logic [7:0] read_data_in = 8'hA5, status_in = 8'h3C;
	logic host_bus_oe_out, strobe_a_in, strobe_b_in, chip_select_n_in;
	logic data_command_select_in, cmd_valid_out, data_valid_out;
	logic read_ack_out, read_is_data_out, init_out;
	wire logic [7:0] host_bus_in = host_bus_oe_out ? host_bus_out : mbus;
	int bad_count = 0, cmp_count = 0, cnt[3] = '{0, 0, 0}, e[3];
	ohp_row_s r;
	// Kind 0 command, 1 data, 2 read answer, 3 nothing expected
	ohp_row_s rows[9] = '{'{2'h0, 1'h0, 1'h0, 1'h0, 8'h3A, 2'h0},
		'{2'h0, 1'h0, 1'h0, 1'h1, 8'hC5, 2'h1}, '{2'h0, 1'h0, 1'h1, 1'h0, 8'h3C, 2'h2},
		'{2'h1, 1'h0, 1'h0, 1'h0, 8'h81, 2'h0}, '{2'h1, 1'h0, 1'h0, 1'h1, 8'h7E, 2'h1},
		'{2'h1, 1'h0, 1'h1, 1'h1, 8'hA5, 2'h2}, '{2'h1, 1'h1, 1'h0, 1'h1, 8'h55, 2'h3},
		'{2'h2, 1'h0, 1'h0, 1'h1, 8'h96, 2'h1}, '{2'h3, 1'h0, 1'h0, 1'h1, 8'h69, 2'h0}};
	ohp_host_port ohp_host_port_inst (.*);
	ohp_host_model ohp_host_model_inst (.clock_in(clock_in), .mode_in(mode_in),
		.bus_in(host_bus_in), .bus_out(mbus), .sa_out(strobe_a_in),
		.sb_out(strobe_b_in), .cs_n_out(chip_select_n_in),
		.dc_out(data_command_select_in));
	initial forever #20 clock_in = ~clock_in;
	always @(posedge clock_in) begin
		if (cmd_valid_out === 1'h1) cnt[0]++;
		if (data_valid_out === 1'h1) cnt[1]++;
		if (read_ack_out === 1'h1) cnt[2]++;
	end
	task automatic cmp8(input logic [7:0] a, x);
		cmp_count++;
		if (a !== x) begin
			bad_count++;
			$display("unexpected at %0t: got %h want %h", $time, a, x);
		end
	endtask
	task automatic cmpi(input int a, x);
		cmp8(8'(a), 8'(x));
	endtask
	task automatic end_of_test();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		#100000;
		bad_count++;
		end_of_test();
	end
	initial begin
		repeat (6) @(posedge clock_in);
		#1;
		cmp8({7'h00, init_out}, 8'h01);
		srst_in = 1'h0;
		ohp_host_model_inst.hold();
		foreach (rows[i]) begin
			r = rows[i];
			mode_in = r.mode;
			e = cnt;
			ohp_host_model_inst.xfer(r.cs_n, r.rd, r.dcs, r.b);
			if (r.k != 2'h3) e[r.k]++;
			for (int j = 0; j < 3; j++) cmpi(cnt[j], e[j]);
			v = r.k[1] ? (r.k[0] ? data_byte_out : ohp_host_model_inst.got)
				: (r.k[0] ? data_byte_out : cmd_byte_out);
			cmp8(v, (r.k == 2'h3) ? 8'h7E : r.b);
			if (r.k == 2'h2)
				cmp8({7'h00, read_is_data_out}, {7'h00, r.dcs});
			$display("test %0d done", i);
		end
		reset_n_in = 1'h0;
		ohp_host_model_inst.hold();
		cmp8({7'h00, init_out}, 8'h01);
		reset_n_in = 1'h1;
		ohp_host_model_inst.hold();
		cmp8({7'h00, init_out}, 8'h00);
		$display("test pin reset done");
		srst_in = 1'h1;
		mode_in = ohp_pkg::MODE_8080;
		ohp_host_model_inst.hold();
		cmp8({7'h00, init_out}, 8'h01);
		srst_in = 1'h0;
		ohp_host_model_inst.hold();
		cmp8({7'h00, init_out}, 8'h00);
		e = cnt;
		e[1]++;
		ohp_host_model_inst.xfer(1'h0, 1'h0, 1'h1, 8'h5A);
		for (int j = 0; j < 3; j++) cmpi(cnt[j], e[j]);
		cmp8(data_byte_out, 8'h5A);
		$display("test mid reset done");
		end_of_test();
	end
endmodule // ohp_host_port_tb_top
`default_nettype wire
